// File: src/ppm_pkg.sv
// package for the port pin function mux: register map, field positions, reset values
// assumes a plain register port with read data one cycle after the read strobe
package ppm_pkg;

  // ==========================================================================
  // register map (byte offsets on the plain register port)
  localparam logic [3:0] ADDR_PORT_M_DATA = 4'h0;
  localparam logic [3:0] ADDR_DDRM     = 4'h1;
  localparam logic [3:0] ADDR_PTC      = 4'h2;
  localparam logic [3:0] ADDR_DDRC     = 4'h3;
  localparam logic [3:0] ADDR_PTD      = 4'h4;
  localparam logic [3:0] ADDR_DDRD     = 4'h5;
  localparam logic [3:0] ADDR_PTE      = 4'h6;
  localparam logic [3:0] ADDR_DDRE     = 4'h7;
  localparam logic [3:0] ADDR_PTK      = 4'h8;
  localparam logic [3:0] ADDR_DDRK     = 4'h9;
  localparam logic [3:0] ADDR_PECTL    = 4'hA;
  localparam logic [3:0] ADDR_IRQCTL   = 4'hB;
  localparam logic [3:0] ADDR_ECLKDIV  = 4'hC;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_DATA      = 8'h00;
  localparam logic [7:0] RST_DDR       = 8'h00;
  localparam logic [7:0] RST_PECTL     = 8'h00;
  localparam logic [7:0] RST_IRQCTL    = 8'h00;
  localparam logic [7:0] RST_ECLKDIV   = 8'h00;

  // ==========================================================================
  // field positions
  // port e function control register
  localparam int PECTL_BUSCTL  = 0;   // pe[3:2],pe[6:5] as bus control
  localparam int PECTL_BUSCLK_OUT  = 1;   // bus rate or divided clock on pe4
  localparam int PECTL_CORECLK_OUT = 2;   // core rate clock on pe7
  localparam int PECTL_EBI_C   = 3;   // ports c/d as external data bus
  localparam int PECTL_EBI_K   = 4;   // port k as external address bus / wait
  // interrupt control register
  localparam int IRQ_EN        = 0;   // ext_int_enable_bit
  localparam int IRQ_EDGE      = 1;   // 1: falling edge, 0: low level

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } ppm_pad_drv_t;

  typedef struct packed {
    logic       en;
    logic [1:0] dout;
    logic [1:0] oe;
  } ppm_periph_t;

endpackage

// File: src/ppm_port_pin_mux.sv
// port pin function mux: routes port m, c, d, e and k pads between gpio and peripherals
// assumes pads resolve their own wires from dout/oe; inputs synchronous to ref_clk_in
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module ppm_port_pin_mux
(
  input  wire logic                ref_clk_in,        // 20 mhz bus clock
  input  wire logic                nrst_in,           // sync reset, active low
  input  wire logic [3:0]          addr_in,           // register address
  input  wire logic [7:0]          wdata_in,          // write data
  input  wire logic                wr_in,             // write strobe
  input  wire logic                rd_in,             // read strobe
  output logic      [7:0]          rdata_out,         // read data, cycle after rd_in
  input  wire logic [7:0]          pm_pin_in,         // port m pad levels
  input  wire logic [7:0]          pc_pin_in,         // port c pad levels
  input  wire logic [7:0]          pd_pin_in,         // port d pad levels
  input  wire logic [7:0]          pe_pin_in,         // port e pad levels
  input  wire logic [7:0]          pk_pin_in,         // port k pad levels
  output ppm_pkg::ppm_pad_drv_t    pm_pad_out,        // port m pad drive
  output ppm_pkg::ppm_pad_drv_t    pc_pad_out,        // port c pad drive
  output ppm_pkg::ppm_pad_drv_t    pd_pad_out,        // port d pad drive
  output ppm_pkg::ppm_pad_drv_t    pe_pad_out,        // port e pad drive
  output ppm_pkg::ppm_pad_drv_t    pk_pad_out,        // port k pad drive
  output logic      [7:0]          pe_pullup_out,     // port e pull-up enables
  output logic                     cd_low_thr_out,    // ports c/d reduced threshold
  output logic      [1:0]          pe_low_thr_out,    // pe6:5 reduced threshold
  output logic                     pk7_low_thr_out,   // pk7 reduced threshold
  input  wire logic                emul_mode_in,      // emulation mode
  input  wire logic                low_thr_mode_in,   // bus mode needing low threshold
  input  wire logic                core_clk_in,       // core clock level for pe7
  input  wire ppm_pkg::ppm_periph_t can_ctrl_first_in,  // can1, routed to pm5:4
  input  wire ppm_pkg::ppm_periph_t can_ctrl_second_in, // can_ctrl_second on pm5:4
  input  wire ppm_pkg::ppm_periph_t can_ctrl_third_in,  // can_ctrl_third on pm7:6
  input  wire ppm_pkg::ppm_periph_t can_ctrl_fourth_on_m76_in,     // can_ctrl_fourth on pm7:6
  input  wire ppm_pkg::ppm_periph_t can_ctrl_fourth_on_m54_in,     // can_ctrl_fourth routed to pm5:4
  input  wire ppm_pkg::ppm_periph_t serial_iface_4_in,  // sci4 on pm7:6
  input  wire ppm_pkg::ppm_periph_t serial_periph_1_in, // spi1 routed on pm5:4
  output logic      [7:0]          pm_periph_rx_out,  // pad levels to owning peripheral
  input  wire logic [15:0]         ext_data_out_in,   // external data bus out
  input  wire logic                ext_data_oe_in,    // external data bus drive
  output logic      [15:0]         ext_data_in_out,   // external data bus in
  input  wire logic [6:0]          ext_addr_hi_in,    // address bits 22:16
  output logic                     external_wait_input_out, // wait level to bus
  input  wire logic [3:0]          bus_ctl_in,        // rw, low_byte_strobe, lower_data_select, read_enable_out
  output logic      [1:0]          tag_mode_out,      // tag_high_input/tag_low_input levels
  input  wire logic                int_mask_i_in,     // core maskable interrupt mask
  input  wire logic                int_mask_x_in,     // core high priority mask
  output logic                     ext_int_req_out,   // maskable interrupt request
  output logic                     high_prio_ext_interrupt_out // high priority request
);

  // ==========================================================================
  // registers
  logic [7:0] port_m_data_ff, ddrm_ff, ptc_ff, ddrc_ff, ptd_ff, ddrd_ff;
  logic [7:0] pte_ff, ddre_ff, ptk_ff, ddrk_ff;
  logic [7:0] pectl_ff, irqctl_ff, eclkdiv_ff, rdata_ff;
  logic [7:0] divcnt_ff;
  logic       busclk_div_ff, pe1_prev_ff, irq_edge_ff;
  logic [7:0] nxt_rdata;
  logic       wr_m;

  assign wr_m = wr_in;

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      port_m_data_ff <= ppm_pkg::RST_DATA;
      ddrm_ff   <= ppm_pkg::RST_DDR;
      ptc_ff    <= ppm_pkg::RST_DATA;
      ddrc_ff   <= ppm_pkg::RST_DDR;
      ptd_ff    <= ppm_pkg::RST_DATA;
      ddrd_ff   <= ppm_pkg::RST_DDR;
      pte_ff    <= ppm_pkg::RST_DATA;
      ddre_ff   <= ppm_pkg::RST_DDR;
      ptk_ff    <= ppm_pkg::RST_DATA;
      ddrk_ff   <= ppm_pkg::RST_DDR;
      pectl_ff  <= ppm_pkg::RST_PECTL;
      irqctl_ff <= ppm_pkg::RST_IRQCTL;
      eclkdiv_ff <= ppm_pkg::RST_ECLKDIV;
    end
    else if (wr_m)
    begin
      // data latches update whatever the direction
      case (addr_in)
        ppm_pkg::ADDR_PORT_M_DATA: port_m_data_ff <= wdata_in;
        ppm_pkg::ADDR_DDRM:    ddrm_ff    <= wdata_in;
        ppm_pkg::ADDR_PTC:     ptc_ff     <= wdata_in;
        ppm_pkg::ADDR_DDRC:    ddrc_ff    <= wdata_in;
        ppm_pkg::ADDR_PTD:     ptd_ff     <= wdata_in;
        ppm_pkg::ADDR_DDRD:    ddrd_ff    <= wdata_in;
        ppm_pkg::ADDR_PTE:     pte_ff     <= wdata_in;
        ppm_pkg::ADDR_DDRE:    ddre_ff    <= wdata_in;
        ppm_pkg::ADDR_PTK:     ptk_ff     <= wdata_in;
        ppm_pkg::ADDR_DDRK:    ddrk_ff    <= wdata_in;
        ppm_pkg::ADDR_PECTL:   pectl_ff   <= wdata_in;
        ppm_pkg::ADDR_IRQCTL:  irqctl_ff  <= wdata_in;
        ppm_pkg::ADDR_ECLKDIV: eclkdiv_ff <= wdata_in;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // read mux: latch for outputs, pad level for inputs
  function automatic logic [7:0] rd_mix(input logic [7:0] lat, input logic [7:0] ddr,
                                       input logic [7:0] pin);
    rd_mix = (lat & ddr) | (pin & ~ddr);
  endfunction

  always_comb
  begin
    case (addr_in)
      ppm_pkg::ADDR_PORT_M_DATA: nxt_rdata = rd_mix(port_m_data_ff, ddrm_ff, pm_pin_in);
      ppm_pkg::ADDR_DDRM:    nxt_rdata = ddrm_ff;
      ppm_pkg::ADDR_PTC:     nxt_rdata = rd_mix(ptc_ff, ddrc_ff, pc_pin_in);
      ppm_pkg::ADDR_DDRC:    nxt_rdata = ddrc_ff;
      ppm_pkg::ADDR_PTD:     nxt_rdata = rd_mix(ptd_ff, ddrd_ff, pd_pin_in);
      ppm_pkg::ADDR_DDRD:    nxt_rdata = ddrd_ff;
      ppm_pkg::ADDR_PTE:     nxt_rdata = rd_mix(pte_ff, ddre_ff, pe_pin_in);
      ppm_pkg::ADDR_DDRE:    nxt_rdata = ddre_ff;
      ppm_pkg::ADDR_PTK:     nxt_rdata = rd_mix(ptk_ff, ddrk_ff, pk_pin_in);
      ppm_pkg::ADDR_DDRK:    nxt_rdata = ddrk_ff;
      ppm_pkg::ADDR_PECTL:   nxt_rdata = pectl_ff;
      ppm_pkg::ADDR_IRQCTL:  nxt_rdata = {6'h00, irqctl_ff[1:0]};
      ppm_pkg::ADDR_ECLKDIV: nxt_rdata = eclkdiv_ff;
      default:               nxt_rdata = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      rdata_ff <= 8'h00;
    else if (rd_in)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 8'h00;
  end

  assign rdata_out = rdata_ff;

  // ==========================================================================
  // port m priority resolution, one pin pair at a time
  ppm_pkg::ppm_periph_t m76_win, m54_win;

  always_comb
  begin
    m76_win = '0;
    if (can_ctrl_third_in.en)
      m76_win = can_ctrl_third_in;
    else if (can_ctrl_fourth_on_m76_in.en)
      m76_win = can_ctrl_fourth_on_m76_in;
    else if (serial_iface_4_in.en)
      m76_win = serial_iface_4_in;
  end

  always_comb
  begin
    m54_win = '0;
    if (can_ctrl_second_in.en)
      m54_win = can_ctrl_second_in;
    else if (can_ctrl_first_in.en)
      m54_win = can_ctrl_first_in;
    else if (can_ctrl_fourth_on_m54_in.en)
      m54_win = can_ctrl_fourth_on_m54_in;
    else if (serial_periph_1_in.en)
      m54_win = serial_periph_1_in;
  end

  logic [7:0] pm_own, pm_pdout, pm_poe;
  assign pm_own   = {{2{m76_win.en}}, {2{m54_win.en}}, 4'h0};
  assign pm_pdout = {m76_win.dout, m54_win.dout, 4'h0};
  assign pm_poe   = {m76_win.oe, m54_win.oe, 4'h0};

  // owned pins follow the peripheral, others are plain gpio
  assign pm_pad_out.dout = (pm_pdout & pm_own) | (port_m_data_ff & ~pm_own);
  assign pm_pad_out.oe   = (pm_poe & pm_own) | (ddrm_ff & ~pm_own);
  assign pm_periph_rx_out = pm_pin_in & pm_own;

  // ==========================================================================
  // ports c, d, k: gpio or external bus
  logic ebi_cd, ebi_k;
  assign ebi_cd = pectl_ff[ppm_pkg::PECTL_EBI_C];
  assign ebi_k  = pectl_ff[ppm_pkg::PECTL_EBI_K];

  assign pc_pad_out.dout = ebi_cd ? ext_data_out_in[15:8] : ptc_ff;
  assign pc_pad_out.oe   = ebi_cd ? {8{ext_data_oe_in}} : ddrc_ff;
  assign pd_pad_out.dout = ebi_cd ? ext_data_out_in[7:0] : ptd_ff;
  assign pd_pad_out.oe   = ebi_cd ? {8{ext_data_oe_in}} : ddrd_ff;
  assign ext_data_in_out = ebi_cd ? {pc_pin_in, pd_pin_in} : 16'h0000;
  assign cd_low_thr_out  = low_thr_mode_in;

  assign pk_pad_out.dout = ebi_k ? {1'b0, ext_addr_hi_in} : ptk_ff;
  assign pk_pad_out.oe   = ebi_k ? 8'h7F : ddrk_ff;
  assign external_wait_input_out = ebi_k & ~pk_pin_in[7];
  assign pk7_low_thr_out = low_thr_mode_in;

  // ==========================================================================
  // port e clocks: core rate on pe7, bus or divided rate on pe4
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      divcnt_ff     <= 8'h00;
      busclk_div_ff <= 1'b0;
    end
    else if (divcnt_ff >= eclkdiv_ff)
    begin
      divcnt_ff     <= 8'h00;
      busclk_div_ff <= ~busclk_div_ff;
    end
    else
      divcnt_ff <= divcnt_ff + 8'h01;
  end

  logic busclk_on, coreclk_on, busctl_on, busclk_lvl;
  assign busclk_on  = pectl_ff[ppm_pkg::PECTL_BUSCLK_OUT] | emul_mode_in;
  assign coreclk_on = pectl_ff[ppm_pkg::PECTL_CORECLK_OUT] | emul_mode_in;
  assign busctl_on  = pectl_ff[ppm_pkg::PECTL_BUSCTL];
  // divider of zero gives the plain bus clock
  assign busclk_lvl = (eclkdiv_ff == 8'h00) ? ref_clk_in : busclk_div_ff;

  logic [7:0] pe_alt, pe_adout;
  assign pe_alt   = {coreclk_on, {2{busctl_on}}, busclk_on, {2{busctl_on}}, 2'b00};
  assign pe_adout = {core_clk_in, bus_ctl_in[1:0], busclk_lvl, bus_ctl_in[3:2], 2'b00};

  // pe1 and pe0 are inputs only
  assign pe_pad_out.dout = (pe_adout & pe_alt) | (pte_ff & ~pe_alt & 8'hFC);
  assign pe_pad_out.oe   = pe_alt | (ddre_ff & 8'hFC);
  assign pe_pullup_out   = 8'h03;
  assign pe_low_thr_out  = {2{low_thr_mode_in}};
  assign tag_mode_out    = pe_pin_in[3:2];

  // ==========================================================================
  // interrupt inputs
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      pe1_prev_ff <= 1'b1;
      irq_edge_ff <= 1'b0;
    end
    else
    begin
      pe1_prev_ff <= pe_pin_in[1];
      if (pe1_prev_ff & ~pe_pin_in[1])
        irq_edge_ff <= 1'b1;
      else if (!irqctl_ff[ppm_pkg::IRQ_EN] || !irqctl_ff[ppm_pkg::IRQ_EDGE])
        irq_edge_ff <= 1'b0;
    end
  end

  logic irq_src;
  assign irq_src = irqctl_ff[ppm_pkg::IRQ_EDGE] ? irq_edge_ff : ~pe_pin_in[1];
  assign ext_int_req_out = irqctl_ff[ppm_pkg::IRQ_EN] & ~int_mask_i_in & irq_src;
  assign high_prio_ext_interrupt_out = ~int_mask_x_in & ~pe_pin_in[0];

endmodule

`default_nettype wire

// File: bench/ppm_periph_model.sv
// stand-in for one peripheral sharing a port m pin pair
// assumes the bench drives en_in; PAT is the pattern it sends while enabled
`timescale 1ns/1ns
`default_nettype none
module ppm_periph_model
#(parameter logic [1:0] PAT = 2'h1)
(
  input  wire logic           clk_in,  // bus clock
  input  wire logic           en_in,   // module enable
  output ppm_pkg::ppm_periph_t per_out  // drive towards the mux
);
  logic [1:0] idle_ff = 2'h0;
  // released lines keep changing so a stale value never matches
  always_ff @(posedge clk_in)
  begin
    idle_ff <= ~idle_ff;
  end
  assign per_out = en_in ? {1'b1, PAT, 2'h2} : {1'b0, idle_ff, 2'h0};
endmodule
`default_nettype wire

// File: bench/ppm_port_pin_mux_chk.sv
// assertions for the port pin function mux
// assumes it is bound into ppm_port_pin_mux and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module ppm_port_pin_mux_chk
(
  input wire logic                  ref_clk_in,  // bus clock
  input wire logic                  nrst_in,     // sync reset
  input wire logic [3:0]            addr_in,     // address
  input wire logic [7:0]            wdata_in,    // write data
  input wire logic                  wr_in,       // write strobe
  input wire logic                  rd_in,       // read strobe
  input wire logic [7:0]            rdata_out,   // read data
  input wire logic [7:0]            pm_pin_in,   // port m pads
  input wire logic [7:0]            pe_pin_in,   // port e pads
  input wire ppm_pkg::ppm_pad_drv_t pm_pad_out,  // port m drive
  input wire ppm_pkg::ppm_pad_drv_t pe_pad_out,  // port e drive
  input wire logic [7:0]            pm_periph_rx_out, // to peripherals
  input wire ppm_pkg::ppm_periph_t  can_ctrl_second_in, // pm5:4 top
  input wire ppm_pkg::ppm_periph_t  can_ctrl_third_in,  // pm7:6 top
  input wire logic                  emul_mode_in,     // emulation
  input wire logic                  low_thr_mode_in,  // bus mode
  input wire logic                  cd_low_thr_out,   // c/d threshold
  input wire logic                  int_mask_x_in,    // core mask
  input wire logic                  high_prio_ext_interrupt_out // request
);
  // ==========================================================================
  // shadow of port m latch and direction
  logic [7:0] lat_ff;
  logic [7:0] ddr_ff;
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      {lat_ff, ddr_ff} <= 16'h0000;
    else if (wr_in && addr_in == ppm_pkg::ADDR_PORT_M_DATA)
      lat_ff <= wdata_in;
    else if (wr_in && addr_in == ppm_pkg::ADDR_DDRM)
      ddr_ff <= wdata_in;
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  property p_pm_read;
    rd_in && addr_in == ppm_pkg::ADDR_PORT_M_DATA |=>
      rdata_out == ((lat_ff & ddr_ff) | ($past(pm_pin_in) & ~ddr_ff));
  endproperty
  a_pm_read: assert property (p_pm_read) else $error("port m read wrong");
  property p_gpio;
    pm_pad_out.oe[3:0] == ddr_ff[3:0]
      && (pm_pad_out.dout[3:0] & ddr_ff[3:0]) == (lat_ff[3:0] & ddr_ff[3:0]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("port m gpio drive wrong");
  property p_third;
    can_ctrl_third_in.en |-> pm_pad_out.dout[7:6] == can_ctrl_third_in.dout
      && pm_pad_out.oe[7:6] == can_ctrl_third_in.oe;
  endproperty
  a_third: assert property (p_third) else $error("pm7:6 owner wrong");
  property p_second;
    can_ctrl_second_in.en |-> pm_pad_out.dout[5:4] == can_ctrl_second_in.dout
      && pm_pad_out.oe[5:4] == can_ctrl_second_in.oe;
  endproperty
  a_second: assert property (p_second) else $error("pm5:4 owner wrong");
  property p_rx;
    can_ctrl_third_in.en |-> pm_periph_rx_out[7:6] == pm_pin_in[7:6];
  endproperty
  a_rx: assert property (p_rx) else $error("pm7:6 receive path wrong");
  property p_emul;
    emul_mode_in |-> pe_pad_out.oe[7] && pe_pad_out.oe[4];
  endproperty
  a_emul: assert property (p_emul) else $error("clock outputs off in emulation");
  property p_thr;
    cd_low_thr_out == low_thr_mode_in;
  endproperty
  a_thr: assert property (p_thr) else $error("c/d threshold wrong");
  property p_high_prio_ext_interrupt;
    high_prio_ext_interrupt_out == (!int_mask_x_in && !pe_pin_in[0]);
  endproperty
  a_high_prio_ext_interrupt: assert property (p_high_prio_ext_interrupt) else $error("high priority request wrong");
endmodule
bind ppm_port_pin_mux ppm_port_pin_mux_chk i_chk (.*);
`default_nettype wire

// File: bench/port_pin_function_mux_test.sv
// self-checking bench for the port pin function mux
// assumes ppm_pkg, the mux, the checker and the peripheral stand-in
`timescale 1ns/1ns
`default_nettype none
module port_pin_function_mux_test;
  logic ref_clk_in, nrst_in, wr_in, rd_in, emul_mode_in, low_thr_mode_in, core_clk_in;
  logic ext_data_oe_in, int_mask_i_in, int_mask_x_in, cd_low_thr_out, pk7_low_thr_out;
  logic external_wait_input_out, ext_int_req_out, high_prio_ext_interrupt_out;
  logic [3:0] addr_in, bus_ctl_in;
  logic [7:0] wdata_in, rdata_out, pm_pin_in, pc_pin_in, pd_pin_in, pe_pin_in, pk_pin_in;
  logic [7:0] pe_pullup_out, pm_periph_rx_out;
  logic [1:0] pe_low_thr_out, tag_mode_out;
  logic [15:0] ext_data_out_in, ext_data_in_out;
  logic [6:0] ext_addr_hi_in, pen;
  ppm_pkg::ppm_pad_drv_t pm_pad_out, pc_pad_out, pd_pad_out, pe_pad_out, pk_pad_out;
  ppm_pkg::ppm_periph_t can_ctrl_first_in, can_ctrl_second_in, can_ctrl_third_in;
  ppm_pkg::ppm_periph_t can_ctrl_fourth_on_m76_in, can_ctrl_fourth_on_m54_in, serial_iface_4_in, serial_periph_1_in;
  ppm_pkg::ppm_periph_t per [7];
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  function automatic logic [1:0] pat(input int k);
    return 2'(k < 3 ? k + 1 : k - 3);
  endfunction
  ppm_port_pin_mux i_dut (.*);
  // index order follows priority: 0..2 on pm7:6, 3..6 on pm5:4
  for (genvar g = 0; g < 7; g++)
  begin : g_per
    ppm_periph_model #(.PAT(pat(g))) i_per (.clk_in(ref_clk_in), .en_in(pen[g]), .per_out(per[g]));
  end
  assign {can_ctrl_third_in, can_ctrl_fourth_on_m76_in, serial_iface_4_in} = {per[0], per[1], per[2]};
  assign {can_ctrl_second_in, can_ctrl_first_in} = {per[3], per[4]};
  assign {can_ctrl_fourth_on_m54_in, serial_periph_1_in} = {per[5], per[6]};
  // ==========================================================================
  // clock, watchdog, common tasks
  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task rd_chk(input logic [3:0] a, input logic [7:0] e);
    {rd_in, addr_in} <= {1'b1, a};
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    check("rdata", rdata_out, e);
    @(posedge ref_clk_in);
  endtask
  // ==========================================================================
  // scenarios
  task t_reset;
    rd_chk(ppm_pkg::ADDR_PORT_M_DATA, 8'h00);
    check("pullup", pe_pullup_out[1:0], 2'h3);
    check("irq", {ext_int_req_out, high_prio_ext_interrupt_out}, 2'h0);
  endtask
  task t_gpio;
    pm_pin_in <= 8'h3C;
    wr_reg(ppm_pkg::ADDR_DDRM, 8'hF0);
    wr_reg(ppm_pkg::ADDR_PORT_M_DATA, 8'hA5);
    rd_chk(ppm_pkg::ADDR_PORT_M_DATA, 8'hAC);
    check("pm drive", {pm_pad_out.oe, pm_pad_out.dout & 8'hF0}, 16'hF0A0);
    wr_reg(ppm_pkg::ADDR_DDRM, 8'h0F);
    wr_reg(4'hF, 8'hFF);
    rd_chk(ppm_pkg::ADDR_PORT_M_DATA, 8'h35);
  endtask
  task t_prio;
    int k;
    int j;
    wr_reg(ppm_pkg::ADDR_DDRM, 8'hFF);
    wr_reg(ppm_pkg::ADDR_PORT_M_DATA, 8'h60);
    pm_pin_in <= 8'h9C;
    for (int i = 0; i < 128; i++)
    begin
      pen <= 7'(i);
      @(negedge ref_clk_in);
      k = 3;
      j = 7;
      for (int b = 6; b >= 0; b--)
        if (pen[b] && b < 3)
          k = b;
        else if (pen[b])
          j = b;
      check("pm76", {pm_pad_out.dout[7:6], pm_pad_out.oe[7:6]}, k == 3 ? 4'h7 : {pat(k), 2'h2});
      check("pm54", {pm_pad_out.dout[5:4], pm_pad_out.oe[5:4]}, j == 7 ? 4'hB : {pat(j), 2'h2});
      check("rx", pm_periph_rx_out[7:4], {k == 3 ? 2'h0 : 2'h2, j == 7 ? 2'h0 : 2'h1});
      @(posedge ref_clk_in);
    end
    pen <= 7'h00;
  endtask
  task t_pe;
    {emul_mode_in, low_thr_mode_in, bus_ctl_in} <= {2'h3, 4'hA};
    wr_reg(ppm_pkg::ADDR_PECTL, 8'h01);
    check("clk oe", {pe_pad_out.oe[7], pe_pad_out.oe[4]}, 2'h3);
    check("thr", {cd_low_thr_out, pe_low_thr_out, pk7_low_thr_out}, 4'hF);
    check("bus ctl", {pe_pad_out.dout[6:5], pe_pad_out.dout[3:2]}, 4'hA);
    {emul_mode_in, low_thr_mode_in} <= 2'h0;
  endtask
  task t_irq;
    wr_reg(ppm_pkg::ADDR_IRQCTL, 8'h01);
    int_mask_x_in <= 1'b0;
    @(negedge ref_clk_in);
    check("irq on", {ext_int_req_out, high_prio_ext_interrupt_out}, 2'h3);
    @(posedge ref_clk_in);
    {int_mask_i_in, pe_pin_in} <= {1'b1, 8'h09};
    @(negedge ref_clk_in);
    check("irq off", {ext_int_req_out, high_prio_ext_interrupt_out}, 2'h0);
    check("tag mode", tag_mode_out, 2'h2);
    @(posedge ref_clk_in);
  endtask
  task t_bus;
    {ext_data_out_in, ext_data_oe_in, ext_addr_hi_in} <= {16'hA55A, 1'b1, 7'h55};
    {pc_pin_in, pd_pin_in} <= 16'h1234;
    wr_reg(ppm_pkg::ADDR_PECTL, 8'h18);
    check("cd out", {pc_pad_out.dout, pd_pad_out.dout}, 16'hA55A);
    check("cd oe", {pc_pad_out.oe, pd_pad_out.oe}, 16'hFFFF);
    check("data in", ext_data_in_out, 16'h1234);
    check("addr", {pk_pad_out.dout[6:0], pk_pad_out.oe[6:0]}, {7'h55, 7'h7F});
    check("wait", external_wait_input_out, 1'b1);
  endtask
  initial
  begin
    {nrst_in, wr_in, rd_in, emul_mode_in, low_thr_mode_in, core_clk_in} = 6'h00;
    {ext_data_oe_in, int_mask_i_in, int_mask_x_in, pen} = {3'h1, 7'h00};
    {addr_in, bus_ctl_in, wdata_in, ext_data_out_in, ext_addr_hi_in} = 39'h0;
    {pm_pin_in, pc_pin_in, pd_pin_in, pe_pin_in, pk_pin_in} = 40'h0;
    repeat (10) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    t_reset();
    t_gpio();
    t_prio();
    t_pe();
    t_irq();
    t_bus();
    give_verdict();
  end
endmodule
`default_nettype wire
